// ===== misc_pkg.sv
// constants and carrier types of the miscellaneous register group
// Overview of operation
// - output pin drives written data bit
// - input pin read returns sampled level, 0 when input disabled
// - panel mode 10 hands pins 3..0 over
// - source divided by two to divide field
// - divided clock further divided by 256
// - force-high bit holds pulse pin high
// - two-bit field selects pulse clock source
// - enable low stops pulse counters and drives pulse pin low unless force-high is set
// - power save stops pulse circuitry
// - duty N gives N high of 256
// - scratch pads store 32 bits, no effect
// - scratch pads are not cleared by reset
// - direction bit one means output, default input
`default_nettype none
package misc_pkg;
    // ****************************************************************
    // register map
    // ****************************************************************
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_PIN_DATA = 8'h64;
    localparam logic [7:0] OFS_PULSE_CFG = 8'h70;
    localparam logic [7:0] OFS_PULSE_DUTY = 8'h74;
    localparam logic [7:0] OFS_SCRATCH_A = 8'h80;
    localparam logic [7:0] OFS_SCRATCH_B = 8'h84;
    localparam logic [7:0] OFS_SCRATCH_C = 8'h88;
    // ****************************************************************
    // fields and reset values
    // ****************************************************************
    localparam int CFG_EN_BIT = 0;
    localparam int CFG_SRC_LSB = 1;
    localparam int CFG_FORCE_BIT = 3;
    localparam int CFG_DIV_LSB = 4;
    localparam int PIN_COUNT = 6;
    localparam int PANEL_PINS = 4;
    localparam logic [3:0] RST_DIV = 4'h0;
    localparam logic [1:0] RST_SRC = 2'h0;
    localparam logic [7:0] RST_DUTY = 8'h00;
    localparam logic [5:0] RST_PIN_DATA = 6'h00;
    localparam logic [1:0] PANEL_DIRECT = 2'h2;
    localparam logic [1:0] SRC_CLK_ONE = 2'h0;
    localparam logic [1:0] SRC_CLK_TWO = 2'h1;
    localparam logic [1:0] SRC_BUS_CLK = 2'h2;
    localparam logic [1:0] SRC_PIXEL_CLK = 2'h3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ****************************************************************
    // bus carriers
    // ****************************************************************
    typedef struct packed {
        logic [ADDR_W-1:0] awaddr;
        logic awvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [ADDR_W-1:0] araddr;
        logic arvalid;
        logic rready;
    } axil_req_t;
    typedef struct packed {
        logic awready;
        logic wready;
        logic [1:0] bresp;
        logic bvalid;
        logic arready;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic rvalid;
    } axil_rsp_t;
endpackage
`default_nettype wire

// ===== misc_regs.sv
// pulse output generator, pin data bits and scratch pads behind axi4-lite
`timescale 1ns/1ps
`default_nettype none
module misc_regs (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic ce_i,
    input wire misc_pkg::axil_req_t axi_i,
    output misc_pkg::axil_rsp_t axi_o,
    input wire logic input_clock_one_i,
    input wire logic input_clock_two_i,
    input wire logic pixel_clock_i,
    input wire logic power_save_i,
    input wire logic [1:0] panel_if_mode_i,
    input wire logic panel_start_pulse_i,
    input wire logic panel_reverse_i,
    input wire logic panel_shift_clock_i,
    input wire logic panel_power_save_i,
    input wire logic [5:0] pin_dir_i,
    input wire logic [5:0] pin_in_en_i,
    input wire logic [5:0] pin_i,
    output logic [5:0] pin_o,
    output logic [5:0] pin_oe_b_o,
    output logic pulse_out_pin_o
);
    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        logic [misc_pkg::ADDR_W-1:0] aw_addr;
        logic aw_got;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic w_got;
        logic bvalid;
        logic [1:0] bresp;
        logic [misc_pkg::ADDR_W-1:0] ar_addr;
        logic rd_busy;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [3:0] div_sel;
        logic force_high;
        logic [1:0] src_sel;
        logic pulse_en;
        logic [7:0] duty;
        logic [5:0] pin_data;
        logic [5:0] pin_out;
        logic [5:0] pin_oe_b;
        logic [2:0] src_prev;
        logic [14:0] pre_cnt;
        logic [7:0] duty_cnt;
        logic pulse_out;
    } state_t;

    state_t q;
    state_t d;

    logic panel_direct;
    logic do_write;
    logic scratch_we;
    logic scratch_re;
    logic [31:0] scratch_rdata;
    logic [2:0] src_now;
    logic src_tick;
    logic [15:0] div_mask;
    logic div_tick;
    logic running;
    logic [5:0] panel_sig;
    logic [5:0] pin_read;
    logic [31:0] cfg_word;

    assign panel_direct = (panel_if_mode_i == misc_pkg::PANEL_DIRECT);
    assign panel_sig = {2'h0, panel_start_pulse_i, panel_reverse_i,
                        panel_shift_clock_i, panel_power_save_i};
    assign do_write = q.aw_got && q.w_got && !q.bvalid;
    assign scratch_we = do_write && q.aw_addr >= misc_pkg::OFS_SCRATCH_A
                        && q.aw_addr <= misc_pkg::OFS_SCRATCH_C
                        && q.aw_addr[1:0] == 2'h0;
    assign scratch_re = axi_o.arready && axi_i.arvalid;
    assign cfg_word = {24'h0, q.div_sel, q.force_high, q.src_sel,
                       q.pulse_en};

    // ****************************************************************
    // bus handshakes
    // ****************************************************************
    always_comb begin
        axi_o.awready = ce_i && !q.aw_got && !q.bvalid;
        axi_o.wready = ce_i && !q.w_got && !q.bvalid;
        axi_o.bvalid = q.bvalid;
        axi_o.bresp = q.bresp;
        axi_o.arready = ce_i && !q.rd_busy && !q.rvalid;
        axi_o.rvalid = q.rvalid;
        axi_o.rdata = q.rdata;
        axi_o.rresp = q.rresp;
    end

    scratch_store u_scratch (
        .clk_i(clk_i),
        .ce_i(ce_i),
        .we_i(scratch_we),
        .waddr_i(q.aw_addr[3:2]),
        .wdata_i(q.w_data),
        .wstrb_i(q.w_strb),
        .re_i(scratch_re),
        .raddr_i(axi_i.araddr[3:2]),
        .rdata_o(scratch_rdata)
    );

    // ****************************************************************
    // pulse clock source and dividers
    // ****************************************************************
    assign src_now = {pixel_clock_i, input_clock_two_i, input_clock_one_i};
    assign running = q.pulse_en && !power_save_i;
    assign div_mask = (16'h1 << q.div_sel) - 16'h1;
    assign div_tick = src_tick
                      && ((q.pre_cnt & div_mask[14:0]) == div_mask[14:0]);

    always_comb begin
        case (q.src_sel)
            misc_pkg::SRC_CLK_ONE: src_tick = src_now[0] && !q.src_prev[0];
            misc_pkg::SRC_CLK_TWO: src_tick = src_now[1] && !q.src_prev[1];
            misc_pkg::SRC_BUS_CLK: src_tick = 1'b1;
            misc_pkg::SRC_PIXEL_CLK: src_tick = src_now[2] && !q.src_prev[2];
            default: src_tick = 1'b0;
        endcase
    end

    // ****************************************************************
    // pin read-back
    // ****************************************************************
    always_comb begin
        for (int i = 0; i < misc_pkg::PIN_COUNT; i++) begin
            if (q.pin_oe_b[i] == 1'b0) begin
                pin_read[i] = q.pin_out[i];
            end else if (pin_in_en_i[i]) begin
                pin_read[i] = pin_i[i];
            end else begin
                pin_read[i] = 1'b0;
            end
        end
    end

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        d = q;
        d.src_prev = src_now;

        // write path: address and data taken in either order
        if (axi_i.awvalid && axi_o.awready) begin
            d.aw_addr = axi_i.awaddr;
            d.aw_got = 1'b1;
        end
        if (axi_i.wvalid && axi_o.wready) begin
            d.w_data = axi_i.wdata;
            d.w_strb = axi_i.wstrb;
            d.w_got = 1'b1;
        end
        if (do_write) begin
            d.aw_got = 1'b0;
            d.w_got = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = misc_pkg::RESP_OKAY;
            case (q.aw_addr)
                misc_pkg::OFS_PIN_DATA: begin
                    for (int i = 0; i < misc_pkg::PIN_COUNT; i++) begin
                        if (!(panel_direct && i < misc_pkg::PANEL_PINS)
                            && q.w_strb[0]) begin
                            d.pin_data[i] = q.w_data[i];
                        end
                    end
                end
                misc_pkg::OFS_PULSE_CFG: begin
                    if (q.w_strb[0]) begin
                        d.pulse_en = q.w_data[misc_pkg::CFG_EN_BIT];
                        d.src_sel = q.w_data[misc_pkg::CFG_SRC_LSB +: 2];
                        d.force_high = q.w_data[misc_pkg::CFG_FORCE_BIT];
                        d.div_sel = q.w_data[misc_pkg::CFG_DIV_LSB +: 4];
                    end
                end
                misc_pkg::OFS_PULSE_DUTY: begin
                    if (q.w_strb[0]) begin
                        d.duty = q.w_data[7:0];
                    end
                end
                misc_pkg::OFS_SCRATCH_A,
                misc_pkg::OFS_SCRATCH_B,
                misc_pkg::OFS_SCRATCH_C: begin
                    d.bresp = misc_pkg::RESP_OKAY;
                end
                default: begin
                    d.bresp = misc_pkg::RESP_SLVERR;
                end
            endcase
        end
        if (q.bvalid && axi_i.bready) begin
            d.bvalid = 1'b0;
        end

        // read path: address taken, data loaded one cycle later
        if (scratch_re) begin
            d.ar_addr = axi_i.araddr;
            d.rd_busy = 1'b1;
        end
        if (q.rd_busy) begin
            d.rd_busy = 1'b0;
            d.rvalid = 1'b1;
            d.rresp = misc_pkg::RESP_OKAY;
            case (q.ar_addr)
                misc_pkg::OFS_PIN_DATA: d.rdata = {26'h0, pin_read};
                misc_pkg::OFS_PULSE_CFG: d.rdata = cfg_word;
                misc_pkg::OFS_PULSE_DUTY: d.rdata = {24'h0, q.duty};
                misc_pkg::OFS_SCRATCH_A,
                misc_pkg::OFS_SCRATCH_B,
                misc_pkg::OFS_SCRATCH_C: d.rdata = scratch_rdata;
                default: begin
                    d.rdata = 32'h0;
                    d.rresp = misc_pkg::RESP_SLVERR;
                end
            endcase
        end
        if (q.rvalid && axi_i.rready) begin
            d.rvalid = 1'b0;
        end

        // pulse generator: prescaler, then 256-step duty counter
        if (!running) begin
            d.pre_cnt = 15'h0;
            d.duty_cnt = 8'h0;
        end else if (src_tick) begin
            d.pre_cnt = q.pre_cnt + 15'h1;
            if (div_tick) begin
                d.duty_cnt = q.duty_cnt + 8'h1;
            end
        end
        if (q.force_high) begin
            d.pulse_out = 1'b1;
        end else if (!running) begin
            d.pulse_out = 1'b0;
        end else begin
            d.pulse_out = (q.duty_cnt < q.duty);
        end

        // pin drivers
        for (int i = 0; i < misc_pkg::PIN_COUNT; i++) begin
            if (panel_direct && i < misc_pkg::PANEL_PINS) begin
                d.pin_out[i] = panel_sig[i];
                d.pin_oe_b[i] = 1'b0;
            end else begin
                d.pin_out[i] = d.pin_data[i];
                d.pin_oe_b[i] = !pin_dir_i[i];
            end
        end
    end

    // ****************************************************************
    // state register
    // ****************************************************************
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            q <= '0;
            q.div_sel <= misc_pkg::RST_DIV;
            q.src_sel <= misc_pkg::RST_SRC;
            q.duty <= misc_pkg::RST_DUTY;
            q.pin_data <= misc_pkg::RST_PIN_DATA;
            q.pin_oe_b <= 6'h3f;
        end else if (ce_i) begin
            q <= d;
        end
    end

    assign pin_o = q.pin_out;
    assign pin_oe_b_o = q.pin_oe_b;
    assign pulse_out_pin_o = q.pulse_out;
endmodule
`default_nettype wire

// ===== misc_regs_chk.sv
// checker of bus timing, pin routing and pulse stop behaviour
`timescale 1ns/1ps
`default_nettype none
module misc_regs_chk (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire misc_pkg::axil_req_t axi_i,
    input wire misc_pkg::axil_rsp_t axi_o,
    input wire logic power_save_i,
    input wire logic [1:0] panel_if_mode_i,
    input wire logic panel_start_pulse_i,
    input wire logic panel_reverse_i,
    input wire logic panel_shift_clock_i,
    input wire logic panel_power_save_i,
    input wire logic [5:0] pin_dir_i,
    input wire logic [5:0] pin_o,
    input wire logic [5:0] pin_oe_b_o,
    input wire logic pulse_out_pin_o
);
    // ****************************************************************
    // bus handshake properties
    // ****************************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    a_write_answer: assert property (axi_i.awvalid && axi_o.awready &&
        axi_i.wvalid && axi_o.wready |-> ##2 axi_o.bvalid)
        else $error("write answer not two cycles after take");
    a_read_answer: assert property (axi_i.arvalid && axi_o.arready
        |-> ##2 axi_o.rvalid)
        else $error("read answer not two cycles after take");
    a_write_release: assert property (axi_o.bvalid && axi_i.bready
        |=> !axi_o.bvalid)
        else $error("write answer held after handshake");
    a_read_release: assert property (axi_o.rvalid && axi_i.rready
        |=> !axi_o.rvalid)
        else $error("read answer held after handshake");
    a_write_busy_refuse: assert property (axi_o.bvalid
        |-> !axi_o.awready && !axi_o.wready)
        else $error("write taken while answer pending");
    a_read_busy_refuse: assert property (axi_o.rvalid |-> !axi_o.arready)
        else $error("read taken while answer pending");
    // ****************************************************************
    // pin and pulse properties
    // ****************************************************************
    a_panel_route: assert property (
        panel_if_mode_i == misc_pkg::PANEL_DIRECT |=> pin_oe_b_o[3:0] ==
        4'h0 && pin_o[3:0] == $past({panel_start_pulse_i, panel_reverse_i,
        panel_shift_clock_i, panel_power_save_i}))
        else $error("panel signals not on pins 3 to 0");
    a_dir_enable: assert property (
        1'b1 |=> pin_oe_b_o[5:4] == ~$past(pin_dir_i[5:4]))
        else $error("upper pin enable does not follow direction");
    a_pulse_stop: assert property (
        power_save_i [*3] |-> $stable(pulse_out_pin_o))
        else $error("pulse output moves in power save");
    cover property (axi_o.bvalid && axi_i.bready);
    cover property (axi_o.rvalid && axi_o.rresp == misc_pkg::RESP_SLVERR);
    cover property (panel_if_mode_i == misc_pkg::PANEL_DIRECT);
    cover property (power_save_i && !pulse_out_pin_o);
endmodule
bind misc_regs misc_regs_chk i_chk (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .axi_i(axi_i), .axi_o(axi_o), .power_save_i(power_save_i),
    .panel_if_mode_i(panel_if_mode_i),
    .panel_start_pulse_i(panel_start_pulse_i),
    .panel_reverse_i(panel_reverse_i),
    .panel_shift_clock_i(panel_shift_clock_i),
    .panel_power_save_i(panel_power_save_i), .pin_dir_i(pin_dir_i),
    .pin_o(pin_o), .pin_oe_b_o(pin_oe_b_o),
    .pulse_out_pin_o(pulse_out_pin_o));
`default_nettype wire

// ===== scratch_store.sv
// three-word scratch store, kept across reset, registered read data
`timescale 1ns/1ps
`default_nettype none
module scratch_store (
    input wire logic clk_i,
    input wire logic ce_i,
    input wire logic we_i,
    input wire logic [1:0] waddr_i,
    input wire logic [31:0] wdata_i,
    input wire logic [3:0] wstrb_i,
    input wire logic re_i,
    input wire logic [1:0] raddr_i,
    output logic [31:0] rdata_o
);
    typedef struct packed {
        logic [2:0][31:0] word;
        logic [31:0] rdata;
    } store_t;

    store_t s_q;
    store_t s_d;

    always_comb begin
        s_d = s_q;
        if (we_i && waddr_i < 2'h3) begin
            for (int b = 0; b < 4; b++) begin
                if (wstrb_i[b]) begin
                    s_d.word[waddr_i][b*8 +: 8] = wdata_i[b*8 +: 8];
                end
            end
        end
        if (re_i && raddr_i < 2'h3) begin
            s_d.rdata = s_q.word[raddr_i];
        end
    end

    // no reset: contents survive a device reset
    always_ff @(posedge clk_i) begin
        if (ce_i) begin
            s_q <= s_d;
        end
    end

    assign rdata_o = s_q.rdata;
endmodule
`default_nettype wire

// ===== tb_misc_regs.sv
// self-checking bench of the miscellaneous register group
`timescale 1ns/1ps
`default_nettype none
module tb_misc_regs;
    logic clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    misc_pkg::axil_req_t req = '0;
    misc_pkg::axil_rsp_t rsp;
    logic ps = 1'b0;
    logic ce = 1'b1;
    logic pwm_held;
    int moves = 0;
    logic [1:0] mode = 2'h0;
    logic [3:0] panel = 4'h0;
    logic [5:0] dir = 6'h00;
    logic [5:0] in_en = 6'h00;
    logic [5:0] pin_in = 6'h00;
    logic [2:0] src_q = 3'h0;
    logic [5:0] pin_o;
    logic [5:0] oe_b;
    logic pwm;
    logic [31:0] sv [3] = '{32'h1234_5678, 32'ha5a5_0ff0, 32'h0f1e_2d3c};
    int n_errors = 0;
    int num_checks = 0;
    always #5 clk_i = ~clk_i;
    // source clocks of period 2, 4 and 8 cycles
    always @(posedge clk_i) src_q <= src_q + 3'h1;
    misc_regs i_dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce),
        .axi_i(req), .axi_o(rsp), .input_clock_one_i(src_q[0]),
        .input_clock_two_i(src_q[1]), .pixel_clock_i(src_q[2]),
        .power_save_i(ps), .panel_if_mode_i(mode),
        .panel_start_pulse_i(panel[3]), .panel_reverse_i(panel[2]),
        .panel_shift_clock_i(panel[1]), .panel_power_save_i(panel[0]),
        .pin_dir_i(dir), .pin_in_en_i(in_en), .pin_i(pin_in),
        .pin_o(pin_o), .pin_oe_b_o(oe_b), .pulse_out_pin_o(pwm));
    // ****************************************************************
    // compare, bus and measurement tasks
    // ****************************************************************
    task automatic chk(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
        input logic [1:0] er);
        logic done;
        done = 1'b0;
        @(posedge clk_i);
        req.awaddr <= a;
        req.wdata <= d;
        req.wstrb <= 4'hf;
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        req.bready <= 1'b1;
        for (int i = 0; i < 40 && !done; i++) begin
            @(posedge clk_i);
            if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
            if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
            if (req.bready && rsp.bvalid) begin
                chk("bresp", 32'(er), 32'(rsp.bresp));
                req.bready <= 1'b0;
                done = 1'b1;
            end
        end
        if (!done) chk("write answer", 32'h1, 32'h0);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e,
        input logic [1:0] er);
        logic done;
        done = 1'b0;
        @(posedge clk_i);
        req.araddr <= a;
        req.arvalid <= 1'b1;
        req.rready <= 1'b1;
        for (int i = 0; i < 40 && !done; i++) begin
            @(posedge clk_i);
            if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
            if (req.rready && rsp.rvalid) begin
                chk("rdata", e, rsp.rdata);
                chk("rresp", 32'(er), 32'(rsp.rresp));
                req.rready <= 1'b0;
                done = 1'b1;
            end
        end
        if (!done) chk("read answer", 32'h1, 32'h0);
    endtask
    // settle one window, then count high cycles over the next one
    task automatic meas(input logic [7:0] cfg, input logic [7:0] duty,
        input int w, input int exp);
        int hi;
        hi = 0;
        wr(misc_pkg::OFS_PULSE_DUTY, {24'h0, duty}, misc_pkg::RESP_OKAY);
        wr(misc_pkg::OFS_PULSE_CFG, {24'h0, cfg}, misc_pkg::RESP_OKAY);
        repeat (w) @(posedge clk_i);
        repeat (w) begin
            @(posedge clk_i);
            if (pwm === 1'b1) hi++;
        end
        chk("pulse high count", 32'(exp), 32'(hi));
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        #400_000;
        n_errors++;
        end_sim();
    end
    // ****************************************************************
    // test sequence
    // ****************************************************************
    initial begin
        repeat (6) @(posedge clk_i);
        rst_b_i <= 1'b1;
        rd(misc_pkg::OFS_PULSE_CFG, 32'h0, misc_pkg::RESP_OKAY);
        rd(misc_pkg::OFS_PULSE_DUTY, 32'h0, misc_pkg::RESP_OKAY);
        wr(8'h90, 32'h5a5a_5a5a, misc_pkg::RESP_SLVERR);
        rd(8'h90, 32'h0, misc_pkg::RESP_SLVERR);
        $display("test reset and map done");
        meas(8'h01, 8'h40, 512, 128);
        meas(8'h03, 8'h40, 1024, 256);
        meas(8'h05, 8'h00, 256, 0);
        meas(8'h05, 8'h01, 256, 1);
        meas(8'h05, 8'hff, 256, 255);
        meas(8'h17, 8'h10, 4096, 256);
        meas(8'h35, 8'h80, 2048, 1024);
        rd(misc_pkg::OFS_PULSE_CFG, 32'h35, misc_pkg::RESP_OKAY);
        meas(8'h05, 8'h80, 256, 128);
        // clock enable low: the running pulse output must freeze
        ce <= 1'b0;
        @(posedge clk_i);
        pwm_held = pwm;
        moves = 0;
        repeat (300) begin
            @(posedge clk_i);
            if (pwm !== pwm_held) moves++;
        end
        chk("frozen pulse moves", 32'h0, 32'(moves));
        ce <= 1'b1;
        meas(8'h08, 8'h00, 200, 200);
        meas(8'h0d, 8'h00, 200, 200);
        meas(8'h00, 8'hff, 200, 0);
        @(posedge clk_i);
        ps <= 1'b1;
        meas(8'h05, 8'hff, 200, 0);
        ps <= 1'b0;
        $display("test pulse output done");
        dir <= 6'h3f;
        wr(misc_pkg::OFS_PIN_DATA, 32'h2a, misc_pkg::RESP_OKAY);
        repeat (2) @(posedge clk_i);
        chk("pin drive", 32'h2a, 32'(pin_o));
        chk("pin enable", 32'h0, 32'(oe_b));
        rd(misc_pkg::OFS_PIN_DATA, 32'h2a, misc_pkg::RESP_OKAY);
        dir <= 6'h00;
        in_en <= 6'h3f;
        pin_in <= 6'h15;
        repeat (3) @(posedge clk_i);
        chk("pin release", 32'h3f, 32'(oe_b));
        rd(misc_pkg::OFS_PIN_DATA, 32'h15, misc_pkg::RESP_OKAY);
        in_en <= 6'h0f;
        rd(misc_pkg::OFS_PIN_DATA, 32'h05, misc_pkg::RESP_OKAY);
        dir <= 6'h3f;
        mode <= misc_pkg::PANEL_DIRECT;
        panel <= 4'hb;
        wr(misc_pkg::OFS_PIN_DATA, 32'h00, misc_pkg::RESP_OKAY);
        repeat (2) @(posedge clk_i);
        chk("panel pins", 32'h0b, 32'(pin_o));
        mode <= 2'h0;
        repeat (3) @(posedge clk_i);
        chk("pins after panel", 32'h0a, 32'(pin_o));
        dir <= 6'h00;
        $display("test pins done");
        for (int k = 0; k < 3; k++) begin
            wr(misc_pkg::OFS_SCRATCH_A + 8'(4 * k), sv[k],
                misc_pkg::RESP_OKAY);
            rd(misc_pkg::OFS_SCRATCH_A + 8'(4 * k), sv[k],
                misc_pkg::RESP_OKAY);
        end
        @(posedge clk_i);
        rst_b_i <= 1'b0;
        repeat (6) @(posedge clk_i);
        rst_b_i <= 1'b1;
        for (int k = 0; k < 3; k++) begin
            rd(misc_pkg::OFS_SCRATCH_A + 8'(4 * k), sv[k],
                misc_pkg::RESP_OKAY);
        end
        rd(misc_pkg::OFS_PULSE_CFG, 32'h0, misc_pkg::RESP_OKAY);
        $display("test scratch pads done");
        end_sim();
    end
endmodule
`default_nettype wire
